// File: design/ccp_bank_pkg.sv
// Constants, register map and carrier types of the capture/compare/PWM bank.
// Assumes a 32-bit classic Wishbone register bus with byte addresses.
package ccp_bank_pkg;

  // ****************************************************************
  // Register map (byte offsets)
  // ****************************************************************
  localparam logic [7:0] UNIT_CONTROL_BASE    = 8'h00;  // Unit n at base + n * stride
  localparam logic [7:0] UNIT_VALUE_BASE      = 8'h04;  // Value pair of unit n
  localparam logic [7:0] UNIT_STRIDE          = 8'h08;  // Two words per unit
  localparam logic [7:0] TIMER_SELECT_OFFSET  = 8'h40;  // One select bit per unit
  localparam logic [7:0] TIMER_COUNT_OFFSET   = 8'h44;  // Timer one count
  localparam logic [7:0] TIMER_CONTROL_OFFSET = 8'h48;  // Run and overflow flag
  localparam logic [7:0] EVENT_FLAG_OFFSET    = 8'h4C;  // Unit event flags, write 1 clears

  // ****************************************************************
  // Field positions and reset values
  // ****************************************************************
  localparam int TIMER_RUN_BIT = 0;                       // Timer one runs while set
  localparam int TIMER_OVF_BIT = 1;                       // Overflow flag, write 1 clears
  localparam logic [7:0]  CONTROL_RESET = 8'h00;          // Unit control after reset
  localparam logic [15:0] VALUE_RESET   = 16'h0000;       // Value pair after reset
  localparam logic [15:0] COUNT_RESET   = 16'h0000;       // Timer one count after reset
  localparam logic [3:0]  PRESCALE_FOUR    = 4'h3;        // Last edge of a group of four
  localparam logic [3:0]  PRESCALE_SIXTEEN = 4'hF;        // Last edge of a group of sixteen

  // ****************************************************************
  // Modes of the unit
  // ****************************************************************
  typedef enum logic [3:0] {
    MODE_OFF       = 4'h0,  // Disabled, unit held in reset
    MODE_TOGGLE    = 4'h2,  // Compare, toggle pin
    MODE_FALL      = 4'h4,  // Capture every falling edge
    MODE_RISE      = 4'h5,  // Capture every rising edge
    MODE_RISE4     = 4'h6,  // Capture every 4th rising edge
    MODE_RISE16    = 4'h7,  // Capture every 16th rising edge
    MODE_SET_HIGH  = 4'h8,  // Compare, pin low then high
    MODE_SET_LOW   = 4'h9,  // Compare, pin high then low
    MODE_SOFT      = 4'hA,  // Compare, flag only
    MODE_SPECIAL   = 4'hB   // Compare, special event trigger
  } unit_mode_t;

  // Unit control register content
  typedef struct packed {
    logic [1:0] duty_low_bits;    // Low two bits of the PWM duty
    logic [3:0] unit_mode_field;  // Mode select
  } unit_control_t;

  // Wishbone request from the master
  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] dat;
  } wb_req_t;

endpackage

// File: design/ccp_timer_one.sv
// Timer one: the 16-bit timebase that units may reset by special event.
// Assumes all inputs come from logic on clk_i.
`timescale 1ns/1ns
module ccp_timer_one (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Control from the register file
  input  wire logic        run_i,
  input  wire logic        write_i,
  input  wire logic [15:0] write_data_i,
  input  wire logic        ovf_clear_i,
  // Special event reset from the units
  input  wire logic        event_reset_i,
  // State
  output logic      [15:0] count_o,
  output logic             overflow_o
);
  import ccp_bank_pkg::*;

  // ****************************************************************
  // Count and overflow
  // ****************************************************************
  logic [15:0] next_count;  // Count after this edge
  logic        wrap;        // Natural roll-over from all ones

  assign wrap = run_i && (count_o == 16'hFFFF) && !event_reset_i;

  // Software write first, then the event reset, then counting
  always_comb begin
    if (write_i) begin
      next_count = write_data_i;
    end else if (event_reset_i) begin
      next_count = COUNT_RESET;
    end else if (run_i) begin
      next_count = count_o + 16'h0001;
    end else begin
      next_count = count_o;
    end
  end

  // The event reset leaves the overflow flag alone; a set beats a clear
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      count_o    <= COUNT_RESET;
      overflow_o <= 1'b0;
    end else begin
      count_o    <= next_count;
      overflow_o <= (overflow_o && !ovf_clear_i) || wrap;
    end
  end

endmodule

// File: design/ccp_unit.sv
// One capture/compare/PWM unit.
// Assumes the pin level is already synchronised and the count is on clk_i.
`timescale 1ns/1ns
module ccp_unit (
  // Clock and reset
  input  wire logic                          clk_i,
  input  wire logic                          rst_i,
  // Configuration
  input  wire ccp_bank_pkg::unit_control_t   control_i,
  input  wire logic                   [15:0] value_i,
  input  wire logic                   [15:0] count_i,
  // Pin
  input  wire logic                          pin_level_i,
  output logic                               pin_o,
  output logic                               pin_oe_o,
  // Events, one-cycle pulses
  output logic                               capture_o,
  output logic                               match_o,
  output logic                               special_o
);
  import ccp_bank_pkg::*;

  // ****************************************************************
  // Decode
  // ****************************************************************
  unit_mode_t mode;        // Current mode
  logic [3:0] mode_prev;   // Mode of the last cycle
  logic       pin_prev;    // Pin level of the last cycle
  logic [3:0] prescale;    // Edge counter
  logic       match_prev;  // Match of the last cycle
  logic       is_capture;  // Capture modes
  logic       is_compare;  // Compare modes
  logic       is_pwm;      // PWM modes 11xx
  logic       edge_seen;   // Edge that the mode listens to
  logic       fire;        // Capture now
  logic       hit;         // First cycle of a match
  logic       pwm_level;   // PWM output level
  logic       next_pin;    // Pin latch after this edge

  assign mode       = unit_mode_t'(control_i.unit_mode_field);
  assign is_capture = control_i.unit_mode_field[3:2] == 2'b01;
  assign is_pwm     = control_i.unit_mode_field[3:2] == 2'b11;
  assign is_compare = (mode == MODE_TOGGLE) || (control_i.unit_mode_field[3:2] == 2'b10);
  assign edge_seen  = (mode == MODE_FALL) ? (pin_prev && !pin_level_i)
                                          : (!pin_prev && pin_level_i);
  // Duty is ten bits: the value byte above the two control bits
  assign pwm_level  = {value_i[7:0], control_i.duty_low_bits} > count_i[9:0];
  assign hit        = (count_i == value_i) && !match_prev;

  // Capture on each edge, on every 4th, or on every 16th
  always_comb begin
    unique case (mode)
      MODE_RISE4:  fire = edge_seen && (prescale[1:0] == PRESCALE_FOUR[1:0]);
      MODE_RISE16: fire = edge_seen && (prescale == PRESCALE_SIXTEEN);
      default:     fire = edge_seen && is_capture;
    endcase
  end

  assign capture_o = fire;
  assign match_o   = hit && is_compare;
  assign special_o = hit && (mode == MODE_SPECIAL);

  // ****************************************************************
  // Pin latch
  // ****************************************************************
  // A new mode sets the initial level; a match then acts on it
  always_comb begin
    next_pin = pin_o;
    if (is_pwm) begin
      next_pin = pwm_level;
    end else if (control_i.unit_mode_field != mode_prev) begin
      next_pin = (mode == MODE_SET_LOW);
    end else if (hit) begin
      unique case (mode)
        MODE_TOGGLE:   next_pin = !pin_o;
        MODE_SET_HIGH: next_pin = 1'b1;
        MODE_SET_LOW:  next_pin = 1'b0;
        default:       next_pin = pin_o;
      endcase
    end
  end

  // Mode zero returns every piece of state to its reset value
  always_ff @(posedge clk_i) begin
    if (rst_i || mode == MODE_OFF) begin
      mode_prev  <= 4'h0;
      pin_prev   <= 1'b0;
      prescale   <= 4'h0;
      match_prev <= 1'b0;
      pin_o      <= 1'b0;
      pin_oe_o   <= 1'b0;
    end else begin
      mode_prev  <= control_i.unit_mode_field;
      pin_prev   <= pin_level_i;
      prescale   <= (is_capture && edge_seen) ? prescale + 4'h1 : prescale;
      match_prev <= count_i == value_i;
      pin_o      <= next_pin;
      pin_oe_o   <= is_pwm || (is_compare && mode != MODE_SOFT && mode != MODE_SPECIAL);
    end
  end

endmodule

// File: design/ccp_bank.sv
// Bank of capture/compare/PWM units with timer one and a Wishbone slave.
// Assumes a classic Wishbone master on clk_i and asynchronous capture pins.
//
// Contract
// - Seven identical capture, compare, PWM units
// - Each unit holds one 16-bit value
// - Small variant: units nine, ten off, selects zero
// - Mode 0101 captures every rising edge, flags
// - Mode 0110 captures every fourth rising edge
// - Mode 1011 flags, resets timer, no conversion; only units on timer one reset it
// - Event reset clears count, not overflow flag
// - Timer write beats simultaneous event reset
// - Value acts as timer period, wraps; only in mode 1011 on timer one
`timescale 1ns/1ns
module ccp_bank #(
  parameter int NUM_UNITS    = 7,  // Units four through ten
  parameter bit SMALL_MEMORY = 0   // Small variant drops the last two
) (
  // Clock and reset
  input  wire logic                            clk_i,
  input  wire logic                            rst_i,
  // Wishbone slave
  input  wire ccp_bank_pkg::wb_req_t           wb_req_i,
  output logic                          [31:0] wb_dat_o,
  output logic                                 wb_ack_o,
  // Second timebase chosen by the select bits
  input  wire logic                     [15:0] alt_count_i,
  // Capture/compare pins
  input  wire logic            [NUM_UNITS-1:0] ccp_pin_i,
  output logic                 [NUM_UNITS-1:0] ccp_pin_o,
  output logic                 [NUM_UNITS-1:0] ccp_pin_oe_o,
  // Timer one state
  output logic                          [15:0] timer_one_count_o,
  output logic                                 timer_one_overflow_flag_o
);
  import ccp_bank_pkg::*;

  // ****************************************************************
  // Elaboration checks
  // ****************************************************************
  // The map leaves room for eight units below the timer select word
  if (NUM_UNITS < 1 || NUM_UNITS > 8) begin : g_bad_units
    $error("NUM_UNITS must lie in 1 to 8");
  end

  // ****************************************************************
  // Bus decode
  // ****************************************************************
  logic        req_go;      // New request, not yet answered
  logic        wr;          // Write taken this cycle
  logic [2:0]  unit_idx;    // Unit addressed
  logic        in_units;    // Address inside the unit area
  logic        hit_ctrl;    // Unit control word
  logic        hit_value;   // Unit value word
  logic        hit_select;  // Timer select word
  logic        hit_count;   // Timer count word
  logic        hit_tctrl;   // Timer control word
  logic        hit_flags;   // Event flag word
  logic [15:0] wmask;       // Byte enables of the low half

  assign req_go     = wb_req_i.cyc && wb_req_i.stb && !wb_ack_o;
  assign wr         = req_go && wb_req_i.we;
  assign unit_idx   = wb_req_i.adr[5:3];
  assign in_units   = (wb_req_i.adr[7:6] == 2'b00) && (int'(unit_idx) < NUM_UNITS);
  assign hit_ctrl   = in_units && (wb_req_i.adr[2:0] == UNIT_CONTROL_BASE[2:0]);
  assign hit_value  = in_units && (wb_req_i.adr[2:0] == UNIT_VALUE_BASE[2:0]);
  assign hit_select = wb_req_i.adr == TIMER_SELECT_OFFSET;
  assign hit_count  = wb_req_i.adr == TIMER_COUNT_OFFSET;
  assign hit_tctrl  = wb_req_i.adr == TIMER_CONTROL_OFFSET;
  assign hit_flags  = wb_req_i.adr == EVENT_FLAG_OFFSET;
  assign wmask      = {{8{wb_req_i.sel[1]}}, {8{wb_req_i.sel[0]}}};

  // ****************************************************************
  // Register storage
  // ****************************************************************
  unit_control_t              control  [NUM_UNITS];  // Unit control words
  logic          [15:0]       value    [NUM_UNITS];  // Unit value pairs
  logic          [NUM_UNITS-1:0] select;             // Timebase select, 1 = second
  logic          [NUM_UNITS-1:0] flags;              // Unit event flags
  logic                       timer_run;             // Timer one run bit
  logic          [NUM_UNITS-1:0] present;            // Units that exist
  logic          [NUM_UNITS-1:0] capture;            // Capture pulses
  logic          [NUM_UNITS-1:0] match;              // Compare event pulses
  logic          [NUM_UNITS-1:0] special;            // Special event pulses
  logic          [NUM_UNITS-1:0] sync_a;             // First synchroniser stage
  logic          [NUM_UNITS-1:0] sync_b;             // Second synchroniser stage
  logic          [15:0]       unit_count [NUM_UNITS];  // Timebase seen by each unit
  logic                       event_reset;           // Reset of timer one
  logic                       timer_wr;              // Software write to the count
  logic          [15:0]       timer_wdata;           // Masked count write data

  // Two flops per pin before any unit looks at it
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sync_a <= '0;
      sync_b <= '0;
    end else begin
      sync_a <= ccp_pin_i;
      sync_b <= sync_a;
    end
  end

  // ****************************************************************
  // Units
  // ****************************************************************
  for (genvar i = 0; i < NUM_UNITS; i++) begin : g_unit
    logic ctrl_wr;   // Write to this control word
    logic value_wr;  // Write to this value word

    // The small variant has no ninth or tenth unit
    assign present[i]    = !(SMALL_MEMORY && i >= 5);
    assign ctrl_wr       = wr && hit_ctrl && (int'(unit_idx) == i) && wb_req_i.sel[0];
    assign value_wr      = wr && hit_value && (int'(unit_idx) == i);
    assign unit_count[i] = select[i] ? alt_count_i : timer_one_count_o;

    // Control word: absent units keep mode zero
    always_ff @(posedge clk_i) begin
      if (rst_i || !present[i]) begin
        control[i] <= unit_control_t'(CONTROL_RESET[5:0]);
      end else if (ctrl_wr) begin
        control[i] <= unit_control_t'(wb_req_i.dat[5:0]);
      end
    end

    // Value pair: a capture beats a software write in the same cycle
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        value[i] <= VALUE_RESET;
      end else if (capture[i]) begin
        value[i] <= unit_count[i];
      end else if (value_wr) begin
        value[i] <= (value[i] & ~wmask) | (wb_req_i.dat[15:0] & wmask);
      end
    end

    // Flag: set from the unit wins over a clear by software
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        flags[i] <= 1'b0;
      end else begin
        flags[i] <= (flags[i] && !(wr && hit_flags && wb_req_i.sel[0] && wb_req_i.dat[i]))
                    || capture[i] || match[i];
      end
    end

    ccp_unit u_unit (
      .clk_i       (clk_i),
      .rst_i       (rst_i),
      .control_i   (control[i]),
      .value_i     (value[i]),
      .count_i     (unit_count[i]),
      .pin_level_i (sync_b[i]),
      .pin_o       (ccp_pin_o[i]),
      .pin_oe_o    (ccp_pin_oe_o[i]),
      .capture_o   (capture[i]),
      .match_o     (match[i]),
      .special_o   (special[i])
    );
  end

  // ****************************************************************
  // Timer one
  // ****************************************************************
  // Only units that count on timer one may reset it; no conversion start
  assign event_reset = |(special & ~select & present);
  assign timer_wr    = wr && hit_count && (wb_req_i.sel[1:0] != 2'b00);
  assign timer_wdata = (timer_one_count_o & ~wmask) | (wb_req_i.dat[15:0] & wmask);

  // Run bit of timer one
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      timer_run <= 1'b0;
    end else if (wr && hit_tctrl && wb_req_i.sel[0]) begin
      timer_run <= wb_req_i.dat[TIMER_RUN_BIT];
    end
  end

  // Select bits; absent units read zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      select <= '0;
    end else if (wr && hit_select && wb_req_i.sel[0]) begin
      select <= wb_req_i.dat[NUM_UNITS-1:0] & present;
    end
  end

  ccp_timer_one u_timer (
    .clk_i         (clk_i),
    .rst_i         (rst_i),
    .run_i         (timer_run),
    .write_i       (timer_wr),
    .write_data_i  (timer_wdata),
    .ovf_clear_i   (wr && hit_tctrl && wb_req_i.sel[0] && wb_req_i.dat[TIMER_OVF_BIT]),
    .event_reset_i (event_reset),
    .count_o       (timer_one_count_o),
    .overflow_o    (timer_one_overflow_flag_o)
  );

  // ****************************************************************
  // Read path
  // ****************************************************************
  logic [31:0] rd_word;  // Word for the addressed register

  // Unmapped addresses answer with zero
  always_comb begin
    rd_word = 32'h0000_0000;
    if (hit_ctrl) begin
      rd_word[5:0] = control[unit_idx];
    end else if (hit_value) begin
      rd_word[15:0] = value[unit_idx];
    end else if (hit_select) begin
      rd_word[NUM_UNITS-1:0] = select;
    end else if (hit_count) begin
      rd_word[15:0] = timer_one_count_o;
    end else if (hit_tctrl) begin
      rd_word[TIMER_RUN_BIT] = timer_run;
      rd_word[TIMER_OVF_BIT] = timer_one_overflow_flag_o;
    end else if (hit_flags) begin
      rd_word[NUM_UNITS-1:0] = flags;
    end
  end

  // One wait-free answer the cycle after the request; ack drops again
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= req_go;
      wb_dat_o <= req_go ? rd_word : 32'h0000_0000;
    end
  end

endmodule

// File: testbench/ccp_far_side.sv
// Far side of the bank: capture pins and the second timebase.
// Assumes the bench asks for pin moves on clk_i.
`timescale 1ns/1ns
module ccp_far_side #(
  parameter int N = 7  // Pin count
) (
  // Clock and reset
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  // Requests from the bench
  input  wire logic [N-1:0] flip_i,
  input  wire logic [15:0]  base_i,
  // Towards the design
  output logic      [N-1:0] pin_o,
  output logic      [15:0]  alt_count_o
);
  // Pins move only on request, so every capture edge is deliberate
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pin_o <= '0;
    end else begin
      pin_o <= pin_o ^ flip_i;
    end
  end
  // Held count makes second-timebase captures predictable
  assign alt_count_o = base_i;
endmodule

// File: testbench/ccp_bank_asserts.sv
// Port checker of the bank; shadows unit zero.
// Assumes full-word writes from the master.
`timescale 1ns/1ns
module ccp_bank_asserts
  import ccp_bank_pkg::*;
#(
  parameter int NUM_UNITS    = 7,  // Unit count
  parameter bit SMALL_MEMORY = 0   // Small variant
) (
  // Clock and reset
  input  wire logic                 clk_i,
  input  wire logic                 rst_i,
  // Bus
  input  wire wb_req_t              wb_req_i,
  input  wire logic [31:0]          wb_dat_o,
  input  wire logic                 wb_ack_o,
  // Pins and timer
  input  wire logic [NUM_UNITS-1:0] ccp_pin_o,
  input  wire logic [NUM_UNITS-1:0] ccp_pin_oe_o,
  input  wire logic [15:0]          timer_one_count_o,
  input  wire logic                 timer_one_overflow_flag_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic        take;    // Request taken at this edge
  logic        wr;      // Write taken
  logic        cnt_wr;  // Count write taken
  logic        drv;     // Shadow mode drives the pin
  logic [5:0]  ctl;     // Shadow of unit zero control
  logic [15:0] val;     // Shadow of unit zero value
  logic        alt;     // Unit zero on second timebase
  assign take = wb_req_i.cyc & wb_req_i.stb & ~wb_ack_o;
  assign wr = take & wb_req_i.we & wb_req_i.sel[0];
  assign cnt_wr = wr & (wb_req_i.adr == TIMER_COUNT_OFFSET);
  assign drv = (ctl[3:0] inside {4'h2, 4'h8, 4'h9}) || (ctl[3:2] == 2'b11);
  // Shadows; stale after a capture, so only compare modes use val
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctl <= 6'h00;
      val <= 16'h0000;
      alt <= 1'b0;
    end else if (wr) begin
      if (wb_req_i.adr == UNIT_CONTROL_BASE) ctl <= wb_req_i.dat[5:0];
      if (wb_req_i.adr == UNIT_VALUE_BASE) val <= wb_req_i.dat[15:0];
      if (wb_req_i.adr == TIMER_SELECT_OFFSET) alt <= wb_req_i.dat[0];
    end
  end
  // ****************************************************************
  // Assertions
  // ****************************************************************
  ack_one_cycle_a: assert property (take |=> wb_ack_o)
    else $error("ack late");
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held");
  idle_data_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("data outside ack");
  count_write_a: assert property (cnt_wr |=> timer_one_count_o == $past(wb_req_i.dat[15:0]))
    else $error("count write lost");
  ovf_source_a: assert property ($rose(timer_one_overflow_flag_o)
    |-> $past(timer_one_count_o) == 16'hFFFF)
    else $error("overflow without wrap");
  special_wrap_a: assert property (ctl[3:0] == 4'hB && !alt && $stable(ctl) && !cnt_wr
    && timer_one_count_o == val && $past(timer_one_count_o) != val
    |=> timer_one_count_o == 16'h0000)
    else $error("special event did not clear count");
  pin_drive_a: assert property ($past(drv) == $past(drv, 2)
    |-> ccp_pin_oe_o[0] == $past(drv))
    else $error("pin enable wrong for mode");
  toggle_cause_a: assert property (ctl[3:0] == 4'h2 && $past(ctl[3:0]) == 4'h2
    && $past(ctl[3:0], 2) == 4'h2 && !alt && $changed(ccp_pin_o[0])
    |-> $past(timer_one_count_o) == val || $past(timer_one_count_o, 2) == val)
    else $error("pin toggled without match");
  cov_special: cover property (ctl[3:0] == 4'hB && timer_one_count_o == 16'h0000);
  cov_toggle: cover property (ctl[3:0] == 4'h2 && $changed(ccp_pin_o[0]));
  cov_ovf: cover property ($rose(timer_one_overflow_flag_o));
endmodule
bind ccp_bank ccp_bank_asserts #(.NUM_UNITS(NUM_UNITS), .SMALL_MEMORY(SMALL_MEMORY)) chk (.*);

// File: testbench/tb_top.sv
// Self-checking bench of the bank, full and small variants.
// Assumes the design package is compiled first.
`timescale 1ns/1ns
module tb_top;
  import ccp_bank_pkg::*;
  logic        clk_i = 1'b0;  // 125 MHz clock
  logic        rst_i = 1'b1;  // Reset
  wb_req_t     req [2] = '{default: '0};  // Bus requests per instance
  logic [7:0]  a;             // Base of the unit under test
  logic [31:0] dat [2];       // Read data
  logic        ack [2];       // Acks
  logic [6:0]  flip = '0;     // Pin move requests
  logic [15:0] base = '0;     // Second timebase value
  logic [6:0]  pins;          // Capture pins
  logic [15:0] alt;           // Second timebase
  logic [6:0]  pin_o;         // Pin levels
  logic [6:0]  oe;            // Pin enables
  logic [31:0] rdata;         // Last read data
  logic [31:0] lfsr = 32'h0001_2593;
  logic [15:0] cv, v;         // Chosen count and value
  int          mismatches = 0;
  int          num_checks = 0;
  int          cycles = 0;
  localparam logic [7:0] CTL = UNIT_CONTROL_BASE, VAL = UNIT_VALUE_BASE, SEL = TIMER_SELECT_OFFSET,
    CNT = TIMER_COUNT_OFFSET, TCTL = TIMER_CONTROL_OFFSET, FLG = EVENT_FLAG_OFFSET;
  logic [3:0]  mtab [4] = '{4'h2, 4'h8, 4'h9, 4'hA};
  always #4 clk_i = ~clk_i;
  ccp_far_side far (.clk_i, .rst_i, .flip_i(flip), .base_i(base), .pin_o(pins),
    .alt_count_o(alt));
  ccp_bank dut (.clk_i, .rst_i, .wb_req_i(req[0]), .wb_dat_o(dat[0]), .wb_ack_o(ack[0]),
    .alt_count_i(alt), .ccp_pin_i(pins), .ccp_pin_o(pin_o), .ccp_pin_oe_o(oe),
    .timer_one_count_o(), .timer_one_overflow_flag_o());
  ccp_bank #(.SMALL_MEMORY(1)) dut_small (.clk_i, .rst_i, .wb_req_i(req[1]),
    .wb_dat_o(dat[1]), .wb_ack_o(ack[1]), .alt_count_i(alt), .ccp_pin_i(pins),
    .ccp_pin_o(), .ccp_pin_oe_o(), .timer_one_count_o(), .timer_one_overflow_flag_o());
  function automatic logic [31:0] next_rand(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // One classic cycle; waits for ack, then idles a cycle
  task automatic bus(input int d, input logic we, input logic [7:0] a, input logic [31:0] wd);
    req[d] <= '{1'b1, 1'b1, we, a, 4'hF, wd};
    @(posedge clk_i);
    while (ack[d] !== 1'b1) @(posedge clk_i);
    rdata = dat[d];
    req[d] <= '0;
    @(posedge clk_i);
  endtask
  task automatic wr(input logic [7:0] ad, input logic [31:0] wd);
    bus(0, 1, ad, wd);
  endtask
  task automatic rd(input logic [7:0] ad);
    bus(0, 0, ad, 0);
  endtask
  task automatic pulse(input logic [6:0] m);
    repeat (2) begin
      flip <= m;
      @(posedge clk_i);
      flip <= '0;
      repeat (6) @(posedge clk_i);
    end
  endtask
  task automatic print_verdict();
    if (mismatches == 0 && num_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // Hang guard
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      mismatches++;
      print_verdict();
    end
  end
  initial begin
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    // Control reset value and read back of all seven units
    for (int u = 0; u < 7; u++) begin
      a = UNIT_STRIDE * 8'(u);
      rd(a);
      check("control reset", rdata, 32'h0);
      lfsr = next_rand(lfsr);
      wr(a + VAL, lfsr);
      rd(a + VAL);
      check("value", rdata, {16'h0, lfsr[15:0]});
      wr(a, lfsr & 32'hF0);
      rd(a);
      check("duty bits", rdata, lfsr & 32'h30);
    end
    rd(8'hF0);
    check("unmapped", rdata, 32'h0);
    // Small variant drops the last two units; a still holds unit six
    bus(1, 1, a, 32'h05);
    bus(1, 0, a, 0);
    check("absent unit", rdata, 32'h0);
    bus(1, 1, SEL, 32'h7F);
    bus(1, 0, SEL, 0);
    check("small select", rdata, 32'h1F);
    // Capture on every rising edge, unit one on the second timebase
    lfsr = next_rand(lfsr);
    cv = lfsr[15:0];
    base <= lfsr[31:16];
    wr(SEL, 32'h02);
    wr(CNT, {16'h0, cv});
    wr(CTL, 32'h05);
    wr(CTL + UNIT_STRIDE, 32'h05);
    pulse(7'h03);
    rd(VAL);
    check("capture", rdata, {16'h0, cv});
    rd(VAL + UNIT_STRIDE);
    check("capture alt", rdata, {16'h0, lfsr[31:16]});
    rd(FLG);
    check("capture flags", rdata, 32'h03);
    wr(FLG, 32'h03);
    // Divide-by-four capture, entered from mode zero
    wr(CTL, 32'h00);
    wr(CTL, 32'h06);
    wr(CNT, {16'h0, ~cv});
    for (int k = 1; k <= 4; k++) begin
      pulse(7'h01);
      rd(VAL);
      check("prescaled", rdata, {16'h0, (k == 4) ? ~cv : cv});
      rd(FLG);
      check("prescaled flag", rdata & 32'h1, {31'h0, k == 4});
    end
    wr(FLG, 32'h01);
    // Compare modes, each entered from mode zero
    for (int k = 0; k < 4; k++) begin
      lfsr = next_rand(lfsr);
      v = {1'b0, lfsr[14:0]} + 16'h0100;
      wr(CTL, 32'h00);
      check("enable off", oe[0], 1'b0);
      wr(VAL, {16'h0, v});
      wr(CNT, {16'h0, v - 16'h0008});
      wr(CTL, {28'h0, mtab[k]});
      wr(TCTL, 32'h01);
      repeat (20) @(posedge clk_i);
      wr(TCTL, 32'h00);
      if (k < 3) check("compare pin", pin_o[0], k < 2);
      check("compare enable", oe[0], k < 3);
      rd(FLG);
      check("compare flag", rdata & 32'h1, 32'h1);
      wr(FLG, 32'h01);
    end
    // Special event: value becomes the period, overflow untouched
    v = 16'h0010 + 16'(lfsr[3:0]);
    wr(CTL, 32'h00);
    wr(VAL, {16'h0, v});
    wr(CNT, 32'h0);
    wr(CTL, 32'h0B);
    wr(TCTL, 32'h03);
    repeat (60) @(posedge clk_i);
    wr(TCTL, 32'h00);
    rd(CNT);
    check("period bound", rdata <= {16'h0, v}, 1'b1);
    rd(TCTL);
    check("no overflow", rdata, 32'h0);
    rd(FLG);
    check("special flag", rdata & 32'h1, 32'h1);
    // Real wrap sets the overflow flag
    wr(CTL, 32'h00);
    wr(CNT, 32'hFFFE);
    wr(TCTL, 32'h01);
    wr(TCTL, 32'h00);
    rd(TCTL);
    check("overflow", rdata, 32'h2);
    // PWM threshold uses the duty bits as low bits
    wr(VAL, 32'h0040);
    wr(CTL, 32'h2C);
    for (int k = 0; k < 2; k++) begin
      wr(CNT, 32'h0101 + k);
      repeat (3) @(posedge clk_i);
      check("pwm pin", pin_o[0], 10'h102 > 10'h101 + k);
    end
    print_verdict();
  end
endmodule
